/* File: mflm_top.v */
// Lane mapping of a quad/dual FIFO: input demux, per-FIFO buffers,
// empty/output-ready flags and echo read clock and strobe.
// Assumes port clocks are slow pins sampled by clock; setup pins are
// latched during full_device_reset.
//
// What this block does
// R01 - Quad: four 10-bit lanes from bus
// R02 - Dual: bits 19..0 FIFO 0, 39..20 FIFO 2
// R03 - Each lane uses own clock and enable
// R04 - Unused data inputs should be held low
// R05 - Per-FIFO empty or output-ready flag
// R06 - Echo read clock toggles after data settles
// R07 - Dual: FIFOs 1 and 3 outputs unused
// R08 - Echo strobe marks new word on output
// R09 - Reset latches fall-through select
// R10 - Reset latches quad or dual select
// R11 - Dual width select picks 10 or 20 bits
`timescale 1ns/10ps
`include "mflm_regs.vh"
module mflm_top (
   // Clock and reset
   input wire clock,
   input wire rst,
   // Setup pins, latched during full device reset
   input wire full_device_reset,
   input wire fall_through_select,
   input wire quad_dual_select,
   input wire write_width_select,
   // Write side
   input wire [39:0] data_in,
   input wire [3:0] write_clock,
   input wire [3:0] write_enable_n,
   output wire [3:0] write_ready,
   // Read side
   input wire [3:0] read_clock,
   input wire [3:0] read_enable_n,
   output wire [79:0] data_out,
   output wire [3:0] fifo_empty_n,
   output wire [3:0] echoed_read_clock,
   output wire [3:0] echoed_read_strobe,
   // Latched configuration
   output reg cfg_fall_through,
   output reg cfg_quad,
   output reg cfg_wide
);
   // ----------------------------------------
   // Configuration latch
   // ----------------------------------------
   wire mrs_s;

   mflm_sync u_mrs (
      .clock(clock),
      .rst(rst),
      .async_in(full_device_reset),
      .sync_out(mrs_s)
   );

   always @(posedge clock) begin
      if (rst) begin
         cfg_fall_through <= `MFLM_CFG_RESET;
         cfg_quad <= `MFLM_CFG_RESET;
         cfg_wide <= `MFLM_CFG_RESET;
      end else if (mrs_s) begin
         // R09 latch timing mode
         cfg_fall_through <= fall_through_select;
         // R10 latch quad/dual
         cfg_quad <= quad_dual_select;
         // R11 width only in dual
         cfg_wide <= write_width_select & ~quad_dual_select;
      end
   end

   // ----------------------------------------
   // Decode helpers
   // ----------------------------------------

   // Lane is live in quad, or FIFO 0/2 in dual
   function lane_active;
      input integer idx;
      input quad;
      begin
         lane_active = quad | (idx == 0) | (idx == 2);
      end
   endfunction

   // Wide capture only in dual with width select high
   function lane_wide;
      input quad;
      input wide;
      begin
         lane_wide = ~quad & wide;
      end
   endfunction

   // Read request for the latched timing mode
   function read_request;
      input fall_through;
      input held;
      input enable_n;
      begin
         if (fall_through) begin
            // Head word falls through while the output stage is empty
            read_request = ~held | ~enable_n;
         end else begin
            read_request = ~enable_n;
         end
      end
   endfunction

   // ----------------------------------------
   // Per-FIFO lanes
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < `MFLM_NUM_FIFO; g = g + 1) begin : lane
         // Lane 3 never runs wide; the clamp keeps its slice on the bus
         localparam integer NARROW_LO = g * `MFLM_LANE_W;
         localparam integer WIDE_LO = (g == `MFLM_NUM_FIFO - 1) ? `MFLM_L2_LO :
            g * `MFLM_LANE_W;
         localparam integer OUT_LO = g * `MFLM_WIDE_W;

         wire wclk_s;
         wire wen_s;
         wire rclk_s;
         wire ren_s;
         reg wclk_d;
         reg rclk_d;
         reg [`MFLM_WIDE_W-1:0] wr_word;
         wire wr_valid;
         wire out_valid;
         wire [`MFLM_WIDE_W-1:0] out_word;
         wire rd_edge;
         wire wr_edge;
         wire live;
         reg hold_valid;
         wire pop;
         reg [`MFLM_WIDE_W-1:0] word_q;
         reg strobe_q;
         reg echo_q;

         // ----------------------------------------
         // Write pins into the clock domain
         // ----------------------------------------
         mflm_sync u_wc (
            .clock(clock),
            .rst(rst),
            .async_in(write_clock[g]),
            .sync_out(wclk_s)
         );

         mflm_sync u_we (
            .clock(clock),
            .rst(rst),
            .async_in(write_enable_n[g]),
            .sync_out(wen_s)
         );

         // ----------------------------------------
         // Read pins into the clock domain
         // ----------------------------------------
         mflm_sync u_rc (
            .clock(clock),
            .rst(rst),
            .async_in(read_clock[g]),
            .sync_out(rclk_s)
         );

         mflm_sync u_re (
            .clock(clock),
            .rst(rst),
            .async_in(read_enable_n[g]),
            .sync_out(ren_s)
         );

         // ----------------------------------------
         // Port clock edge detection
         // ----------------------------------------
         // Delay flops reset low, matching the idle pin level
         always @(posedge clock) begin
            if (rst | mrs_s) begin
               wclk_d <= 1'b0;
               rclk_d <= 1'b0;
            end else begin
               wclk_d <= wclk_s;
               rclk_d <= rclk_s;
            end
         end

         assign live = lane_active(g, cfg_quad);
         assign wr_edge = wclk_s & ~wclk_d;
         assign rd_edge = rclk_s & ~rclk_d;

         // ----------------------------------------
         // Write lane capture
         // ----------------------------------------
         // R01 quad 10-bit slice
         // R02 dual 20-bit slice
         // R11 width follows latched select
         always @* begin
            wr_word = {`MFLM_WIDE_W{1'b0}};
            if (lane_wide(cfg_quad, cfg_wide)) begin
               wr_word = data_in[WIDE_LO +: `MFLM_WIDE_W];
            end else begin
               wr_word[`MFLM_LANE_W-1:0] = data_in[NARROW_LO +: `MFLM_LANE_W];
            end
         end

         // R03 own write clock and enable
         assign wr_valid = live & ~mrs_s & wr_edge & ~wen_s;
         assign write_ready[g] = live;

         // ----------------------------------------
         // Lane buffer
         // ----------------------------------------
         // Writes into a full buffer are dropped; no full flag here
         mflm_fifo #(
            .WIDTH(`MFLM_WIDE_W),
            .DEPTH(`MFLM_FIFO_DEPTH),
            .AW(`MFLM_ADDR_W)
         ) u_fifo (
            .clock(clock),
            .rst(rst | mrs_s),
            .in_valid(wr_valid),
            .in_ready(),
            .in_data(wr_word),
            .out_valid(out_valid),
            .out_ready(pop),
            .out_data(out_word)
         );

         // ----------------------------------------
         // Read control
         // ----------------------------------------
         // Only an edge of this lane's own read clock moves data
         assign pop = live & rd_edge & out_valid
            & read_request(cfg_fall_through, hold_valid, ren_s);

         // ----------------------------------------
         // Output word stage
         // ----------------------------------------
         // A new word wins over the fall-through clear
         always @(posedge clock) begin
            if (rst | mrs_s) begin
               word_q <= {`MFLM_WIDE_W{1'b0}};
               hold_valid <= 1'b0;
            end else if (pop) begin
               word_q <= out_word;
               hold_valid <= 1'b1;
            end else if (rd_edge & ~ren_s & cfg_fall_through) begin
               hold_valid <= 1'b0;
            end
         end

         // ----------------------------------------
         // Echo outputs
         // ----------------------------------------
         // R08 strobe with new word
         always @(posedge clock) begin
            if (rst | mrs_s) begin
               strobe_q <= 1'b0;
            end else begin
               strobe_q <= pop;
            end
         end

         // R06 echo after data settles
         // R07 idle in dual
         always @(posedge clock) begin
            if (rst | mrs_s) begin
               echo_q <= 1'b0;
            end else begin
               echo_q <= live & rclk_d;
            end
         end

         assign data_out[OUT_LO +: `MFLM_WIDE_W] = word_q;
         assign echoed_read_strobe[g] = strobe_q;
         assign echoed_read_clock[g] = echo_q;

         // ----------------------------------------
         // Status flag
         // ----------------------------------------
         // R05 empty or output ready
         assign fifo_empty_n[g] = live & (cfg_fall_through ? hold_valid : out_valid);
      end
   endgenerate

   // ----------------------------------------
   // Usage notes
   // ----------------------------------------
   // Port clocks are sampled, so each port clock phase must last longer
   // than one system clock for an edge to be seen. Lanes 1 and 3
   // stay idle in dual, so their outputs may be left unconnected.
   // A master reset empties every lane buffer and clears the read-side outputs.
endmodule

/* File: mflm_regs.vh */
// Constants for the multi-FIFO lane mapping block.
// Assumes inclusion by bare name from the design files.
`ifndef MFLM_REGS_VH
`define MFLM_REGS_VH
`define MFLM_BUS_W 40
`define MFLM_LANE_W 10
`define MFLM_WIDE_W 20
`define MFLM_NUM_FIFO 4
`define MFLM_FIFO_DEPTH 4
`define MFLM_PTR_W 3
`define MFLM_ADDR_W 2
`define MFLM_L0_LO 0
`define MFLM_L1_LO 10
`define MFLM_L2_LO 20
`define MFLM_L3_LO 30
`define MFLM_CNT_ZERO 3'h0
`define MFLM_CNT_ONE 3'h1
`define MFLM_CFG_RESET 1'b0
`endif

/* File: mflm_sync.v */
// Two-flop synchroniser for a level from outside the clock domain.
// Assumes the input is asynchronous to clock.
`timescale 1ns/10ps
module mflm_sync (
   // Clock and reset
   input wire clock,
   input wire rst,
   // Level in and out
   input wire async_in,
   output reg sync_out
);
   reg meta;

   always @(posedge clock) begin
      if (rst) begin
         meta <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         meta <= async_in;
         sync_out <= meta;
      end
   end
endmodule

/* File: mflm_fifo.v */
// Small flop-based FIFO with valid/ready on both sides.
// Assumes a single clock; depth is a power of two.
`timescale 1ns/10ps
`include "mflm_regs.vh"
module mflm_fifo #(
   parameter WIDTH = `MFLM_WIDE_W,
   parameter DEPTH = `MFLM_FIFO_DEPTH,
   parameter AW = 2
) (
   // Clock and reset
   input wire clock,
   input wire rst,
   // Fill side
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   // Drain side
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg [AW:0] count;
   wire push;
   wire pop;

   assign in_ready = (count != DEPTH[AW:0]);
   assign out_valid = (count != {(AW+1){1'b0}});
   assign out_data = mem[rd_ptr];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always @(posedge clock) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always @(posedge clock) begin
      if (rst) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule

/* File: mflm_assertions.sv */
// Port checker for the lane mapping top.
// Assumes it is bound to mflm_top from the bench top.
`timescale 1ns/10ps
module mflm_assertions (
   // Clock, reset, setup
   input wire clock,
   input wire rst,
   input wire full_device_reset,
   input wire fall_through_select,
   input wire quad_dual_select,
   // Port pins
   input wire [3:0] write_clock,
   input wire [3:0] write_enable_n,
   input wire [3:0] write_ready,
   input wire [3:0] read_clock,
   input wire [3:0] read_enable_n,
   input wire [79:0] data_out,
   input wire [3:0] fifo_empty_n,
   input wire [3:0] echoed_read_clock,
   input wire [3:0] echoed_read_strobe,
   input wire cfg_fall_through,
   input wire cfg_quad,
   input wire cfg_wide
);
   //------------------------------
   // Properties
   //------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   sequence s_rclk;
      $rose(read_clock[0]) ##1 read_clock[0] [*3];
   endsequence
   sequence s_wr;
      $rose(write_clock[0]) && !write_enable_n[0] && !full_device_reset && !cfg_fall_through;
   endsequence
   a_lane_ready: assert property (write_ready == (cfg_quad ? 4'hf : 4'h5))
      else $error("lane ready wrong");
   a_dual_unused: assert property (!cfg_quad |-> ((fifo_empty_n | echoed_read_clock) & 4'ha) == 0)
      else $error("unused lane active");
   a_strobe_once: assert property (echoed_read_strobe[0] |=> !echoed_read_strobe[0])
      else $error("strobe too long");
   a_strobe_cause: assert property (echoed_read_strobe[0] && !cfg_fall_through |->
      !$past(read_enable_n[0], 3)) else $error("strobe without read");
   a_echo_clock: assert property (s_rclk |-> ##[0:2] echoed_read_clock[0])
      else $error("echo clock late");
   a_flag_rise: assert property (s_wr |-> ##[1:6] fifo_empty_n[0])
      else $error("flag late");
   a_cfg_latch: assert property (full_device_reset [*5] |-> cfg_quad == $past(quad_dual_select)
      && cfg_fall_through == $past(fall_through_select)) else $error("setup not latched");
   a_cfg_hold: assert property (!full_device_reset [*4] |-> $stable({cfg_quad, cfg_wide}))
      else $error("setup changed");
   a_narrow_lane: assert property (echoed_read_strobe[1] && cfg_quad |-> data_out[39:30] == 0)
      else $error("quad lane wide");
endmodule

/* File: mflm_partner.sv */
// Far-side writer and reader model for the port pins.
// Assumes the bench calls wr and rd; link clocks stand still between transfers.
`timescale 1ns/10ps
module mflm_partner (
   // Clock
   input wire clock,
   // Pins towards the block
   output logic [39:0] data_in = 40'h0,
   output logic [3:0] write_clock = 4'h0,
   output logic [3:0] write_enable_n = 4'hf,
   output logic [3:0] read_clock = 4'h0,
   output logic [3:0] read_enable_n = 4'hf
);
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic wr(input int g, input logic [19:0] w, input logic wide);
      logic [39:0] m;
      m = (wide ? 40'h000f_ffff : 40'h0000_03ff) << (g * 10);
      cyc(1);
      data_in = ({20'h0, w} << (g * 10)) & m;
      write_enable_n[g] = 1'b0;
      cyc(1);
      write_clock[g] = 1'b1;
      cyc(4);
      write_clock[g] = 1'b0;
      cyc(4);
      write_enable_n[g] = 1'b1;
      // Released lane shows a changed value, not the last word
      data_in = ~data_in & m;
   endtask
   // Read clock pulse with enable high, for fall-through preload
   task automatic tick(input int g);
      cyc(1);
      read_clock[g] = 1'b1;
      cyc(4);
      read_clock[g] = 1'b0;
      cyc(4);
   endtask
   task automatic rd(input int g);
      cyc(1);
      read_enable_n[g] = 1'b0;
      cyc(1);
      read_clock[g] = 1'b1;
      cyc(4);
      read_clock[g] = 1'b0;
      cyc(4);
      read_enable_n[g] = 1'b1;
   endtask
endmodule

/* File: tb.sv */
// Self-checking bench for the lane mapping top.
// Assumes the partner model drives every port pin.
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; \
   $display("[FAIL] %0t %h %h", $time, a, b); end end
module tb;
   logic clock = 0, rst = 1, full_device_reset = 0;
   logic fall_through_select = 0, quad_dual_select = 0, write_width_select = 0;
   wire [39:0] data_in;
   wire [3:0] write_clock, write_enable_n, write_ready, read_clock, read_enable_n;
   wire [79:0] data_out;
   wire [3:0] fifo_empty_n, echoed_read_clock, echoed_read_strobe;
   wire cfg_fall_through, cfg_quad, cfg_wide;
   int fail_count = 0, comparisons = 0;
   logic [31:0] x = 32'h0000_bdc6;
   logic [21:0] q[$];
   logic [21:0] e;
   mflm_top mflm_top_inst (.*);
   mflm_partner mflm_partner_inst (.*);
   initial forever #12.5 clock = ~clock;
   function automatic logic [19:0] rnd();
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x[19:0];
   endfunction
   task automatic put(input int g, input logic wide, input logic kept);
      logic [19:0] w;
      w = rnd();
      if (kept) q.push_back({g[1:0], wide ? w : {10'h000, w[9:0]}});
      mflm_partner_inst.wr(g, w, wide);
   endtask
   task automatic cfg(input logic qd, input logic ft, input logic ww);
      @(posedge clock);
      #1 full_device_reset = 1;
      quad_dual_select = qd;
      fall_through_select = ft;
      write_width_select = ww;
      repeat (6) @(posedge clock);
      #1 full_device_reset = 0;
      repeat (4) @(posedge clock);
      #1 `CHK({cfg_quad, cfg_fall_through, cfg_wide}, {qd, ft, ww & ~qd})
   endtask
   task automatic conclude();
      if (fail_count == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   //------------------------------
   // Result watcher
   //------------------------------
   always @(posedge clock) begin
      for (int g = 0; g < 4; g++) begin
         if (echoed_read_strobe[g] === 1'b1) begin
            e = (q.size() > 0) ? q.pop_front() : 22'h3f_ffff;
            `CHK(data_out[g*20+:20], e[19:0])
            `CHK(g[1:0], e[21:20])
         end
      end
   end
   initial begin
      #100000;
      fail_count++;
      conclude();
   end
   //------------------------------
   // Main sequence
   //------------------------------
   initial begin
      repeat (4) @(posedge clock);
      #1 rst = 0;
      cfg(1, 0, 0);
      for (int g = 0; g < 4; g++) put(g, 0, 1);
      for (int g = 0; g < 4; g++) mflm_partner_inst.rd(g);
      // Fifth word overflows the 4-deep buffer and is dropped
      for (int i = 0; i < 5; i++) put(0, 0, i < 4);
      for (int i = 0; i < 4; i++) mflm_partner_inst.rd(0);
      `CHK(fifo_empty_n[0], 1'b0)
      cfg(0, 0, 1);
      put(0, 1, 1);
      put(2, 1, 1);
      mflm_partner_inst.rd(0);
      mflm_partner_inst.rd(2);
      `CHK(fifo_empty_n, 4'h0)
      cfg(0, 1, 0);
      put(0, 0, 1);
      mflm_partner_inst.tick(0);
      repeat (10) @(posedge clock);
      #1 `CHK(fifo_empty_n[0], 1'b1)
      `CHK(q.size(), 0)
      conclude();
   end
endmodule
bind mflm_top mflm_assertions mflm_assertions_inst (.*);
